// File: core/io_control_spi_slave.sv
`timescale 1ns/100ps
module io_control_spi_slave #(
    parameter int unsigned IRQ_W = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic             clkEn,
    input  wire logic             sharedBusStrap,
    input  wire logic             ioCtlChipSelect_n,
    input  wire logic             ioCtlSerialClock,
    input  wire logic             ioCtlSerialIn,
    output logic                  ioCtlSerialOut,
    output logic                  ioCtlSerialOutEn,
    input  wire logic             pdSerialClock,
    input  wire logic             pdSerialIn,
    output logic                  pdSerialOut,
    output logic                  pdSerialOutEn,
    output logic [15:0]           regAddr,
    output logic [11:0]           regNum,
    output logic [3:0]            regByteIdx,
    output logic                  regRdStb,
    input  wire logic [7:0]       regRdData,
    output logic                  regWrStb,
    output logic [7:0]            regWrData,
    input  wire logic [IRQ_W-1:0] irqSources,
    input  wire logic [IRQ_W-1:0] irqEnable,
    output logic                  ioBlockIrq
);

    // ***************************************************************
    // pin synchronisers
    // ***************************************************************
    // both pin sets are synchronised so the strap can pick either cleanly
    logic [5:0] syncA_r;
    logic [5:0] syncB_r;
    logic       sckPrev_r;
    logic       csnS;
    logic       sckS;
    logic       mosiS;
    logic       strapS;
    logic       sckRise;
    logic       sckFall;

    // idle-high reset of the clock bits keeps a false edge from following reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            syncA_r   <= io_ctl_spi_pkg::SYNC_RST;
            syncB_r   <= io_ctl_spi_pkg::SYNC_RST;
            sckPrev_r <= 1'b1;
        end else if (clkEn) begin
            syncA_r   <= {sharedBusStrap, pdSerialIn, pdSerialClock,
                          ioCtlSerialIn, ioCtlSerialClock, ioCtlChipSelect_n};
            syncB_r   <= syncA_r;
            sckPrev_r <= sckS;
        end
    end

    assign csnS    = syncB_r[0];
    assign strapS  = syncB_r[5];
    assign sckS    = strapS ? syncB_r[3] : syncB_r[1];
    assign mosiS   = strapS ? syncB_r[4] : syncB_r[2];
    assign sckRise = sckS & ~sckPrev_r;
    assign sckFall = ~sckS & sckPrev_r;

    // ***************************************************************
    // protocol engine
    // ***************************************************************
    // no network state input: access never depends on it
    io_ctl_spi_pkg::state_e state_r, state_nxt;
    logic [2:0]  bitCnt_r, bitCnt_nxt;
    logic [6:0]  rxSh_r, rxSh_nxt;
    logic [7:0]  txSh_r, txSh_nxt;
    logic [7:0]  txNext_r, txNext_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic        rdStb_r, rdStb_nxt;
    logic        wrStb_r, wrStb_nxt;
    logic [7:0]  wrData_r, wrData_nxt;
    logic        dedEn_r, dedEn_nxt;
    logic        pdEn_r, pdEn_nxt;
    logic        irq_r, irq_nxt;
    logic [7:0]  rxByte;
    logic [7:0]  statusByte;
    logic [IRQ_W-1:0] pending;

    assign rxByte     = {rxSh_r, mosiS};
    assign pending    = irqSources & irqEnable;
    // pending sources are echoed during the address bytes
    assign statusByte = 8'(pending);

    function automatic io_ctl_spi_pkg::state_e dispatch(input logic [2:0] cmd);
        case (cmd)
            io_ctl_spi_pkg::CMD_READ:      dispatch = io_ctl_spi_pkg::ST_READ;
            io_ctl_spi_pkg::CMD_READ_WAIT: dispatch = io_ctl_spi_pkg::ST_WAIT;
            io_ctl_spi_pkg::CMD_WRITE:     dispatch = io_ctl_spi_pkg::ST_WRITE;
            io_ctl_spi_pkg::CMD_EXT:       dispatch = io_ctl_spi_pkg::ST_ADDR2;
            default:                       dispatch = io_ctl_spi_pkg::ST_DONE;
        endcase
    endfunction : dispatch

    always_comb begin
        state_nxt  = state_r;
        bitCnt_nxt = bitCnt_r;
        rxSh_nxt   = rxSh_r;
        txSh_nxt   = txSh_r;
        txNext_nxt = txNext_r;
        addr_nxt   = addr_r;
        rdStb_nxt  = 1'b0;
        wrStb_nxt  = 1'b0;
        wrData_nxt = wrData_r;
        irq_nxt    = |pending;
        dedEn_nxt  = ~csnS & ~strapS;
        pdEn_nxt   = ~csnS & strapS;
        if (rdStb_r) begin
            txNext_nxt = regRdData;
        end
        if (rdStb_r || wrStb_r) begin
            addr_nxt = addr_r + 16'h0001;
        end
        if (csnS) begin
            state_nxt  = io_ctl_spi_pkg::ST_ADDR0;
            bitCnt_nxt = 3'h0;
            txNext_nxt = statusByte;
        end else begin
            if (sckFall) begin
                // next byte is loaded at the boundary, so no idle gap is needed
                txSh_nxt = (bitCnt_r == 3'h0) ? txNext_r : {txSh_r[6:0], 1'b0};
            end
            if (sckRise) begin
                rxSh_nxt   = rxByte[6:0];
                bitCnt_nxt = bitCnt_r + 3'h1;
                if (bitCnt_r == io_ctl_spi_pkg::BIT_LAST) begin
                    case (state_r)
                        io_ctl_spi_pkg::ST_ADDR0: begin
                            addr_nxt   = {3'h0, rxByte, 5'h00};
                            txNext_nxt = statusByte;
                            state_nxt  = io_ctl_spi_pkg::ST_ADDR1;
                        end
                        io_ctl_spi_pkg::ST_ADDR1: begin
                            addr_nxt   = {addr_r[15:5], rxByte[7:3]};
                            txNext_nxt = statusByte;
                            state_nxt  = dispatch(rxByte[2:0]);
                            rdStb_nxt  = (rxByte[2:0] == io_ctl_spi_pkg::CMD_READ);
                        end
                        io_ctl_spi_pkg::ST_ADDR2: begin
                            // each repeated extension byte reloads address bits 15:13 from its top three bits
                            addr_nxt   = {rxByte[7:5], addr_r[12:0]};
                            txNext_nxt = statusByte;
                            state_nxt  = dispatch(rxByte[4:2]);
                            rdStb_nxt  = (rxByte[4:2] == io_ctl_spi_pkg::CMD_READ);
                        end
                        io_ctl_spi_pkg::ST_WAIT: begin
                            rdStb_nxt = 1'b1;
                            state_nxt = io_ctl_spi_pkg::ST_READ;
                        end
                        io_ctl_spi_pkg::ST_READ: begin
                            // the final marker byte skips a fetch nobody will read
                            rdStb_nxt = (rxByte != io_ctl_spi_pkg::LAST_BYTE);
                        end
                        io_ctl_spi_pkg::ST_WRITE: begin
                            wrStb_nxt  = 1'b1;
                            wrData_nxt = rxByte;
                        end
                        default: begin
                            state_nxt = io_ctl_spi_pkg::ST_DONE;
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_r  <= io_ctl_spi_pkg::ST_ADDR0;
            bitCnt_r <= 3'h0;
            rxSh_r   <= 7'h00;
            txSh_r   <= io_ctl_spi_pkg::BYTE_RST;
            txNext_r <= io_ctl_spi_pkg::BYTE_RST;
            addr_r   <= io_ctl_spi_pkg::ADDR_RST;
            rdStb_r  <= 1'b0;
            wrStb_r  <= 1'b0;
            wrData_r <= io_ctl_spi_pkg::BYTE_RST;
            dedEn_r  <= 1'b0;
            pdEn_r   <= 1'b0;
            irq_r    <= 1'b0;
        end else if (clkEn) begin
            state_r  <= state_nxt;
            bitCnt_r <= bitCnt_nxt;
            rxSh_r   <= rxSh_nxt;
            txSh_r   <= txSh_nxt;
            txNext_r <= txNext_nxt;
            addr_r   <= addr_nxt;
            rdStb_r  <= rdStb_nxt;
            wrStb_r  <= wrStb_nxt;
            wrData_r <= wrData_nxt;
            dedEn_r  <= dedEn_nxt;
            pdEn_r   <= pdEn_nxt;
            irq_r    <= irq_nxt;
        end
    end

    assign ioCtlSerialOut   = txSh_r[7];
    assign ioCtlSerialOutEn = dedEn_r;
    assign pdSerialOut      = txSh_r[7];
    assign pdSerialOutEn    = pdEn_r;
    assign regAddr          = addr_r;
    assign regNum           = addr_r[15:io_ctl_spi_pkg::REG_SHIFT];
    assign regByteIdx       = addr_r[io_ctl_spi_pkg::REG_SHIFT-1:0];
    assign regRdStb         = rdStb_r;
    assign regWrStb         = wrStb_r;
    assign regWrData        = wrData_r;
    assign ioBlockIrq       = irq_r;

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence selDropped;
        clkEn && csnS;
    endsequence
    sequence strobeOut;
        clkEn && (rdStb_r || wrStb_r);
    endsequence

    deselect_restart_a: assert property (selDropped |=> state_r == io_ctl_spi_pkg::ST_ADDR0)
        else $error("select high did not restart the address phase");
    addr_inc_a: assert property (strobeOut ##1 clkEn |=> addr_r == $past(addr_r, 2) + 16'h0001)
        else $error("address not incremented after an access");
    write_state_a: assert property (wrStb_r |-> $past(state_r) == io_ctl_spi_pkg::ST_WRITE)
        else $error("write strobe outside a write datagram");
    shared_route_a: assert property (clkEn && strapS |=> !ioCtlSerialOutEn)
        else $error("dedicated output driven in shared mode");
    own_pins_a: assert property (clkEn && !strapS |=> !pdSerialOutEn)
        else $error("shared output driven with separate buses");
    irq_follow_a: assert property (clkEn |=> ioBlockIrq == $past(|pending))
        else $error("interrupt output does not follow enabled sources");
    two_byte_a: assert property (clkEn && !csnS && state_r == io_ctl_spi_pkg::ST_ADDR1
        && state_nxt == io_ctl_spi_pkg::ST_READ |=> addr_r[15:13] == 3'h0 && rdStb_r)
        else $error("two-byte read did not fetch a low address");
    wait_dummy_a: assert property (clkEn && state_r == io_ctl_spi_pkg::ST_WAIT
        && state_nxt == io_ctl_spi_pkg::ST_READ |=> rdStb_r)
        else $error("wait-state byte did not start the fetch");

endmodule : io_control_spi_slave

// File: core/io_ctl_spi_pkg.sv
// Overview of operation
// - mode 3 slave: idle-high clock, sample on rising edge, low-active select.
// - access is accepted whatever the network state machine is doing.
// - datagram, command set and timing match the process data port.
// - byte address is register number shifted left four, plus byte index.
// - two- and three-byte address phases both accepted; two bytes reach only addresses below 2000h.
// - strap low: own pins; strap high: process data bus lines, own select.
// - shared mode routes to process data pins and ignores the dedicated clock and data pins.
// - interrupt request output toward the controller with configurable sources.
// - bytes may follow back to back with no idle gap.
// - command 000 nop, 010 read, 011 read+wait, 100 write, 110 extension.
// - read returns data from address, incrementing; master sends 00, last FF.
// - write stores each byte and increments; no wait state needed.
package io_ctl_spi_pkg;

    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned SCK_MAX_MHZ   = 30;
    localparam int unsigned READ_GAP_NS   = 240;
    localparam int unsigned READ_GAP_CYC  = (READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ***************************************************************
    // address and command layout
    // ***************************************************************
    localparam int unsigned ADDR_W        = 16;
    localparam int unsigned REG_SHIFT     = 4;
    localparam logic [15:0] ADDR_RST      = 16'h0000;
    localparam logic [2:0]  CMD_NOP       = 3'h0;
    localparam logic [2:0]  CMD_READ      = 3'h2;
    localparam logic [2:0]  CMD_READ_WAIT = 3'h3;
    localparam logic [2:0]  CMD_WRITE     = 3'h4;
    localparam logic [2:0]  CMD_EXT       = 3'h6;
    localparam logic [7:0]  LAST_BYTE     = 8'hFF;
    localparam logic [7:0]  BYTE_RST      = 8'h00;
    localparam logic [2:0]  BIT_LAST      = 3'h7;
    // pin synchroniser reset: select and both clock pins at their idle-high level
    localparam logic [5:0]  SYNC_RST      = 6'h0B;

    // ***************************************************************
    // protocol states, gray-coded in declaration order
    // ***************************************************************
    typedef enum logic [2:0] {
        ST_ADDR0 = 3'h0,
        ST_ADDR1 = 3'h1,
        ST_ADDR2 = 3'h3,
        ST_WAIT  = 3'h2,
        ST_READ  = 3'h6,
        ST_WRITE = 3'h7,
        ST_DONE  = 3'h5
    } state_e;

endpackage : io_ctl_spi_pkg

// File: sim/io_control_spi_slave_tb.sv
`timescale 1ns/100ps
module io_control_spi_slave_tb;
    // ****************************************
    // bench
    // ****************************************
    logic        clk_sys, rst_b, strap, sck, mosi, csN, en;
    logic [7:0]  irqSrc, irqEn, rdData;
    logic [7:0]  tx[8];
    logic [7:0]  rx[8];
    logic [15:0] wa[$];
    logic [7:0]  wd[$];
    wire         ioOut, ioEn, pdOut, pdEn, rdStb, wrStb, irq, miso;
    wire  [15:0] addr;
    wire  [11:0] num;
    wire  [3:0]  idx;
    wire  [7:0]  wrData;
    int          errors = 0;
    int          compares = 0;
    // released line toggles so a stale bit cannot pass
    assign miso = strap ? (pdEn ? pdOut : sck) : (ioEn ? ioOut : sck);
    spi_master_model M (.sck(sck), .mosi(mosi), .csN(csN), .miso(miso));
    // unused pin set always carries the inverted traffic
    io_control_spi_slave DUT (.clk_sys(clk_sys), .rst_b(rst_b), .clkEn(en),
        .sharedBusStrap(strap), .ioCtlChipSelect_n(csN),
        .ioCtlSerialClock(strap ? ~sck : sck), .ioCtlSerialIn(strap ? ~mosi : mosi),
        .ioCtlSerialOut(ioOut), .ioCtlSerialOutEn(ioEn),
        .pdSerialClock(strap ? sck : ~sck), .pdSerialIn(strap ? mosi : ~mosi),
        .pdSerialOut(pdOut), .pdSerialOutEn(pdEn), .regAddr(addr), .regNum(num),
        .regByteIdx(idx), .regRdStb(rdStb), .regRdData(rdData), .regWrStb(wrStb),
        .regWrData(wrData), .irqSources(irqSrc), .irqEnable(irqEn), .ioBlockIrq(irq));
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction : pat
    // read data answers inside the strobe cycle, where the core samples it
    assign rdData = (rdStb === 1'b1) ? pat({num, idx}) : 8'h00;
    always @(posedge clk_sys) begin
        if (wrStb === 1'b1) begin
            wa.push_back(addr);
            wd.push_back(wrData);
        end
    end
    task automatic chkByte(input string w, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", w, e, g);
        end
    endtask : chkByte
    task automatic chkAddr(input string w, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", w, e, g);
        end
    endtask : chkAddr
    task automatic ld(input logic [63:0] v);
        for (int i = 0; i < 8; i++) tx[i] = v[63-8*i -: 8];
        wa.delete();
        wd.delete();
    endtask : ld
    task automatic dg(input int n, input int gap);
        M.sel(1'b1);
        for (int i = 0; i < n; i++) begin
            M.xfer(tx[i], rx[i]);
            if (i == 1 && gap != 0) #(gap);
        end
        M.sel(1'b0);
    endtask : dg
    task automatic t_write();
        ld(64'h21044C4800000000);
        dg(4, 0);
        chkByte("status", 8'h0C, rx[0]);
        chkAddr("wcount", 16'h0002, 16'(wa.size()));
        chkAddr("waddr0", 16'h0420, wa[0]);
        chkByte("wdata0", 8'h4C, wd[0]);
        chkAddr("waddr1", 16'h0421, wa[1]);
        chkByte("wdata1", 8'h48, wd[1]);
        $display("write done");
    endtask : t_write
    task automatic t_readWait(input logic s);
        strap <= s;
        repeat (6) @(posedge clk_sys);
        ld(64'h09AB000000FF0000);
        dg(6, 0);
        chkByte("dummy", 8'h0C, rx[2]);
        for (int k = 0; k < 3; k++) chkByte("rdata", pat(16'h0135 + 16'(k)), rx[3+k]);
        $display("read wait done");
    endtask : t_readWait
    task automatic t_readGap();
        ld(64'h108200FF00000000);
        dg(4, 300);
        chkByte("rgap0", pat(16'h0210), rx[2]);
        chkByte("rgap1", pat(16'h0211), rx[3]);
        $display("read gap done");
    endtask : t_readGap
    task automatic t_ext();
        ld(64'h03BE180C00FF0000);
        dg(6, 0);
        chkByte("ext", pat(16'h0077), rx[5]);
        $display("ext done");
    endtask : t_ext
    task automatic t_abort();
        ld(64'h2100000000000000);
        dg(1, 0);
        ld(64'h0284990000000000);
        dg(3, 0);
        chkAddr("acount", 16'h0001, 16'(wa.size()));
        chkAddr("aaddr", 16'h0050, wa[0]);
        chkByte("adata", 8'h99, wd[0]);
        $display("abort done");
    endtask : t_abort
    task automatic t_refuse();
        logic [2:0] c[4];
        c = '{3'h0, 3'h1, 3'h5, 3'h7};
        for (int k = 0; k < 4; k++) begin
            ld({8'h00, 5'h00, c[k], 48'h112200000000});
            dg(4, 0);
            chkAddr("rcount", 16'h0000, 16'(wa.size()));
        end
        $display("refuse done");
    endtask : t_refuse
    task automatic t_irq();
        irqSrc <= 8'hA5;
        repeat (4) @(posedge clk_sys);
        chkByte("irqOn", 8'h01, {7'h00, irq});
        irqEn <= 8'h00;
        repeat (4) @(posedge clk_sys);
        chkByte("irqOff", 8'h00, {7'h00, irq});
        en <= 1'b0;
        irqEn <= 8'h0F;
        repeat (4) @(posedge clk_sys);
        chkByte("irqFrozen", 8'h00, {7'h00, irq});
        en <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chkByte("irqThaw", 8'h01, {7'h00, irq});
        irqSrc <= 8'h3C;
        irqEn <= 8'h0F;
        $display("irq done");
    endtask : t_irq
    task automatic end_sim();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        errors++;
        $display("timeout");
        end_sim();
    end
    initial begin
        rst_b = 1'b0;
        strap = 1'b0;
        irqSrc = 8'h3C;
        irqEn = 8'h0F;
        en = 1'b1;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_write();
        t_readWait(1'b0);
        t_readGap();
        t_ext();
        t_abort();
        t_refuse();
        t_irq();
        t_readWait(1'b1);
        end_sim();
    end
endmodule : io_control_spi_slave_tb

// File: sim/spi_master_model.sv
`timescale 1ns/100ps
module spi_master_model (
    output logic      sck,
    output logic      mosi,
    output logic      csN,
    input  wire logic miso
);
    // ****************************************
    // serial master, mode 3
    // ****************************************
    initial begin
        sck = 1'b1;
        mosi = 1'b1;
        csN = 1'b1;
    end
    // low phase kept long: reply lags the falling edge by up to three system clocks
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck <= 1'b0;
            mosi <= tx[i];
            #250;
            sck <= 1'b1;
            rx[i] = miso;
            #150;
        end
    endtask : xfer
    // clock stands still high outside frames
    task automatic sel(input logic on);
        #300;
        csN <= ~on;
        #300;
    endtask : sel
endmodule : spi_master_model
